/* design/acm_adc_ctrl.sv */
// Converter control: conversion and comparator modes, threshold, done flag
`timescale 1ns/1ps
`default_nettype none
`include "acm_defs.svh"
// Behaviour
// - Mode bit 3 of control register at one selects comparator operation.
// - Load-threshold places accumulator B high, accumulator A low, in 8-bit threshold.
// - Switching into comparator mode leaves conversion result undefined.
// - Threshold is separate storage, kept across return to conversion mode.
// - Threshold reads and writes act only in comparator mode.
// - Threshold n selects reference supply/256 times n on the DAC.
// - In comparator mode the done flag is one when input is below reference.
// - Done flag clears on interrupt taken or skip-if-done skipping.
// - Interrupt select bit chooses interrupt or polling for the done flag.
// - Start in comparator mode finishes eight cycles later and updates the flag.
// - Analog pins keep port function; their digital reading is undefined.
// - Move-low-result puts two low result bits in A's top, zeroes A's bottom.
// - Leaving comparator mode may set the flag; software then skip-tests it.
// - Mode bit at zero selects 10-bit successive-approximation conversion.
// - Channel code 00 selects input zero, 01 input one, others unavailable; here codes 10 and 11 fall back to input zero.
// - Conversion ends 62 cycles after start, stores result, sets flag.
module acm_adc_ctrl (
	input  wire logic               mclk,
	input  wire logic               resetn,
	input  wire acm_pkg::acm_instr_t instr,
	input  wire logic [3:0]         interrupt_select_reg,
	input  wire logic               cmp_below,
	input  wire logic [1:0]         port_in_raw,
	output logic [3:0]              converter_control_reg,
	output logic                    conv_done_flag,
	output logic                    irq_request,
	output logic                    skip_next,
	output logic [9:0]              dac_code,
	output logic [1:0]              analog_sel,
	output logic                    busy,
	output logic [7:0]              threshold_read,
	output logic [9:0]              result_read,
	output logic [3:0]              acc_a_low_result,
	output logic [1:0]              port_in_digital
);
	acm_pkg::acm_state_t state;
	acm_pkg::acm_state_t next_state;
	logic [`ACM_CNT_W-1:0] count;
	logic [7:0]  threshold;
	logic [9:0]  result;
	logic [9:0]  sar_trial;
	logic [9:0]  sar_result;
	logic        below;
	logic        cmp_mode;
	logic        sar_clear;
	logic        sar_step;
	logic        conv_end;
	logic        cmp_end;
	logic        flag_set;
	logic        flag_clr;
	logic        irq_mode;
	logic [1:0]  port_s1;
	logic [1:0]  port_s2;

	// Decoding that several processes share
	function automatic logic chan_valid(input logic [1:0] code);
		chan_valid = (code == `ACM_SEL_ANALOG_INPUT_ZERO) || (code == `ACM_SEL_ANALOG_INPUT_ONE);
	endfunction : chan_valid

	acm_sync u_sync (
		.mclk   (mclk),
		.resetn (resetn),
		.d      (cmp_below),
		.q      (below)
	);

	acm_sar u_sar (
		.mclk    (mclk),
		.resetn  (resetn),
		.clear   (sar_clear),
		.step    (sar_step),
		.cmp_low (below),
		.trial   (sar_trial),
		.result  (sar_result)
	);

	// Mode and channel decode
	assign cmp_mode   = converter_control_reg[`ACM_MODE_POS];
	assign analog_sel = chan_valid(converter_control_reg[`ACM_CHAN_HI:`ACM_CHAN_LO]) ?
		converter_control_reg[`ACM_CHAN_HI:`ACM_CHAN_LO] : `ACM_SEL_ANALOG_INPUT_ZERO;
	assign irq_mode   = interrupt_select_reg[`ACM_IRQ_SEL_BIT];
	assign busy       = (state != acm_pkg::ACM_IDLE);

	// DAC gets threshold over 256 steps in comparator mode, SAR trial over 1024 else
	assign dac_code = cmp_mode ? {threshold, 2'b00} : sar_trial;

	// Sequencer decode
	assign sar_clear = instr.start && !busy;
	// Comparator answer lags the DAC by the two synchroniser stages, so each trial is
	// judged three cycles after it is set; the last step lands one cycle before the store
	assign sar_step  = (state == acm_pkg::ACM_CONV) && (count <= `ACM_SAR_FIRST) &&
		(count >= `ACM_SAR_LAST) && (((count - `ACM_SAR_LAST) % `ACM_SAR_PACE) == `ACM_CNT_ZERO);
	assign conv_end  = (state == acm_pkg::ACM_CONV) && (count == `ACM_CNT_ONE);
	assign cmp_end   = (state == acm_pkg::ACM_CMP) && (count == `ACM_CNT_ONE);

	always_comb begin
		next_state = state;
		case (state)
			acm_pkg::ACM_IDLE: begin
				if (instr.start)
					next_state = cmp_mode ? acm_pkg::ACM_CMP : acm_pkg::ACM_CONV;
			end
			acm_pkg::ACM_CONV: begin
				if (conv_end)
					next_state = acm_pkg::ACM_IDLE;
			end
			acm_pkg::ACM_CMP: begin
				if (cmp_end)
					next_state = acm_pkg::ACM_IDLE;
			end
			default: next_state = acm_pkg::ACM_IDLE;
		endcase
	end

	// Sequencer; a start while busy is ignored so a running job is not corrupted
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state <= acm_pkg::ACM_IDLE;
			count <= `ACM_CNT_ZERO;
		end else begin
			state <= next_state;
			if (instr.start && !busy)
				count <= cmp_mode ? 6'(`ACM_CMP_CYCLES) : 6'(`ACM_CONV_CYCLES);
			else if (count != `ACM_CNT_ZERO)
				count <= count - `ACM_CNT_ONE;
		end
	end

	// Control register; mode toggling while busy is software's burden
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			converter_control_reg <= `ACM_CTRL_RST;
		else if (instr.write_ctrl)
			converter_control_reg <= instr.ctrl_data;
	end

	// Threshold register, writable only in comparator mode, untouched otherwise
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			threshold <= `ACM_THR_ZERO;
		else if (instr.load_thr && cmp_mode)
			threshold <= {instr.acc_b, instr.acc_a};
	end
	assign threshold_read = cmp_mode ? threshold : `ACM_THR_ZERO;

	// Result register: stored at conversion end only; after entering comparator
	// mode it is simply not maintained, so its content is of no meaning
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			result <= `ACM_RES_ZERO;
		else if (conv_end)
			result <= sar_result;
	end
	assign result_read = result;

	// Move-low-result answer
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			acc_a_low_result <= `ACM_LOW_ZERO;
		else if (instr.move_low)
			acc_a_low_result <= {result[1:0], 2'b00};
	end

	// Done flag: set wins over clear when both land in one cycle
	assign flag_set = conv_end || (cmp_end && below);
	assign flag_clr = (instr.irq_ack && irq_mode) ||
		(instr.skip_test && conv_done_flag && !irq_mode);
	assign skip_next   = instr.skip_test && conv_done_flag && !irq_mode;
	assign irq_request = conv_done_flag && irq_mode;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			conv_done_flag <= 1'b0;
		else if (flag_set)
			conv_done_flag <= 1'b1;
		else if (flag_clr)
			conv_done_flag <= 1'b0;
	end

	// Port input readback: the selected analog pin reads undefined, shown as zero here
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			port_s1 <= 2'b00;
			port_s2 <= 2'b00;
		end else begin
			port_s1 <= port_in_raw;
			port_s2 <= port_s1;
		end
	end
	assign port_in_digital = port_s2 & ~(2'b01 << analog_sel);

	// Checks
	property p_cmp_len;
		@(posedge mclk) disable iff (!resetn)
		(instr.start && !busy && cmp_mode) |=> busy[*7] ##1 (busy && cmp_end) ##1 !busy;
	endproperty
	a_cmp_len: assert property (p_cmp_len) else $error("compare not 8 cycles");

	property p_conv_len;
		@(posedge mclk) disable iff (!resetn)
		(instr.start && !busy && !cmp_mode) |-> ##62 conv_end ##1 conv_done_flag;
	endproperty
	a_conv_len: assert property (p_conv_len) else $error("conversion not 62 cycles");

	property p_flag_below;
		@(posedge mclk) disable iff (!resetn)
		(cmp_end && below) |=> conv_done_flag;
	endproperty
	a_flag_below: assert property (p_flag_below) else $error("flag not set on below");

	property p_flag_above;
		@(posedge mclk) disable iff (!resetn)
		(cmp_end && !below && !conv_done_flag) |=> !conv_done_flag;
	endproperty
	a_flag_above: assert property (p_flag_above) else $error("flag set when above");

	property p_skip_clear;
		@(posedge mclk) disable iff (!resetn)
		(skip_next && !flag_set) |=> !conv_done_flag;
	endproperty
	a_skip_clear: assert property (p_skip_clear) else $error("skip did not clear");

	property p_thr_load;
		@(posedge mclk) disable iff (!resetn)
		(instr.load_thr && cmp_mode) |=> threshold == {$past(instr.acc_b), $past(instr.acc_a)};
	endproperty
	a_thr_load: assert property (p_thr_load) else $error("threshold load wrong");

	property p_thr_hold;
		@(posedge mclk) disable iff (!resetn)
		!cmp_mode |=> $stable(threshold);
	endproperty
	a_thr_hold: assert property (p_thr_hold) else $error("threshold changed");

	property p_low_move;
		@(posedge mclk) disable iff (!resetn)
		instr.move_low |=> acc_a_low_result == {$past(result[1:0]), 2'b00};
	endproperty
	a_low_move: assert property (p_low_move) else $error("low result move wrong");

	property p_irq_route;
		@(posedge mclk) disable iff (!resetn)
		irq_request |-> (conv_done_flag && irq_mode && !skip_next);
	endproperty
	a_irq_route: assert property (p_irq_route) else $error("irq routing wrong");

	property p_start_refused;
		@(posedge mclk) disable iff (!resetn)
		(instr.start && busy) |=> count == ($past(count) - `ACM_CNT_ONE);
	endproperty
	a_start_refused: assert property (p_start_refused) else $error("start taken while busy");

	property p_ack_poll;
		@(posedge mclk) disable iff (!resetn)
		(instr.irq_ack && !irq_mode && !instr.skip_test && conv_done_flag) |=> conv_done_flag;
	endproperty
	a_ack_poll: assert property (p_ack_poll) else $error("ack cleared flag in poll mode");

	property p_conv_store;
		@(posedge mclk) disable iff (!resetn)
		conv_end |=> (conv_done_flag && (result == $past(sar_result)));
	endproperty
	a_conv_store: assert property (p_conv_store) else $error("conversion end not stored");

	property p_result_hold;
		@(posedge mclk) disable iff (!resetn)
		!conv_end |=> $stable(result);
	endproperty
	a_result_hold: assert property (p_result_hold) else $error("result changed off end");

	property p_sel_legal;
		@(posedge mclk) disable iff (!resetn)
		chan_valid(analog_sel);
	endproperty
	a_sel_legal: assert property (p_sel_legal) else $error("unavailable channel selected");

	property p_flag_ack;
		@(posedge mclk) disable iff (!resetn)
		(instr.irq_ack && irq_mode && !flag_set) |=> !conv_done_flag;
	endproperty
	a_flag_ack: assert property (p_flag_ack) else $error("interrupt taken, flag kept");

	property p_skip_irq;
		@(posedge mclk) disable iff (!resetn)
		(instr.skip_test && irq_mode) |-> !skip_next;
	endproperty
	a_skip_irq: assert property (p_skip_irq) else $error("skip answered in irq mode");

	property p_low_zero;
		@(posedge mclk) disable iff (!resetn)
		acc_a_low_result[1:0] == 2'b00;
	endproperty
	a_low_zero: assert property (p_low_zero) else $error("low accumulator bits not zero");
endmodule : acm_adc_ctrl
`default_nettype wire

/* design/acm_defs.svh */
// Constants for the converter comparator-mode control block
`ifndef ACM_DEFS_SVH
`define ACM_DEFS_SVH
`define ACM_MODE_BIT        2
`define ACM_MODE_POS        3
`define ACM_CHAN_LO         0
`define ACM_CHAN_HI         1
`define ACM_CTRL_RST        4'h0
`define ACM_CONV_CYCLES     62
`define ACM_CMP_CYCLES      8
`define ACM_CNT_W           6
`define ACM_CNT_ONE         6'h01
`define ACM_CNT_ZERO        6'h00
`define ACM_RES_ZERO        10'h000
`define ACM_THR_ZERO        8'h00
`define ACM_SEL_ANALOG_INPUT_ZERO        2'h0
`define ACM_SEL_ANALOG_INPUT_ONE        2'h1
`define ACM_IRQ_SEL_BIT     2
`define ACM_SAR_FIRST       6'h1d
`define ACM_SAR_LAST        6'h02
`define ACM_SAR_PACE        6'h03
`define ACM_SAR_TOP         4'h9
`define ACM_SAR_SPENT       4'hf
`define ACM_SAR_UNIT        10'h001
`define ACM_LOW_ZERO        4'h0
`endif

/* design/acm_pkg.sv */
// Types for the converter comparator-mode control block
package acm_pkg;
	typedef enum logic [1:0] {ACM_IDLE, ACM_CONV, ACM_CMP} acm_state_t;
	// Instruction strobes from the CPU core, one machine cycle each
	typedef struct packed {
		logic       write_ctrl;
		logic [3:0] ctrl_data;
		logic       start;
		logic       skip_test;
		logic       load_thr;
		logic       move_low;
		logic       irq_ack;
		logic [3:0] acc_a;
		logic [3:0] acc_b;
	} acm_instr_t;
endpackage : acm_pkg

/* design/acm_sar.sv */
// Successive-approximation step engine for the 10-bit conversion
`timescale 1ns/1ps
`default_nettype none
`include "acm_defs.svh"
module acm_sar (
	input  wire logic       mclk,
	input  wire logic       resetn,
	input  wire logic       clear,
	input  wire logic       step,
	input  wire logic       cmp_low,
	output logic [9:0]      trial,
	output logic [9:0]      result
);
	logic [3:0] bit_idx;
	logic [9:0] next_result;
	// Keep the tried bit only when the reference stayed at or below the input
	assign trial       = result | (`ACM_SAR_UNIT << bit_idx);
	assign next_result = cmp_low ? result : trial;
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			result  <= `ACM_RES_ZERO;
			bit_idx <= `ACM_SAR_TOP;
		end else if (clear) begin
			result  <= `ACM_RES_ZERO;
			bit_idx <= `ACM_SAR_TOP;
		end else if (step && bit_idx != `ACM_SAR_SPENT) begin
			result  <= next_result;
			bit_idx <= bit_idx - 4'h1;
		end
	end
endmodule : acm_sar
`default_nettype wire

/* design/acm_sync.sv */
// Two-stage synchroniser for the analog comparator output
`timescale 1ns/1ps
`default_nettype none
module acm_sync (
	input  wire logic mclk,
	input  wire logic resetn,
	input  wire logic d,
	output logic      q
);
	logic meta;
	// Comparator output is asynchronous to the machine clock
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			meta <= 1'b0;
			q    <= 1'b0;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule : acm_sync
`default_nettype wire

/* verif/acm_adc_ctrl_tb.sv */
// Self-checking bench for the converter comparator-mode control block
`timescale 1ns/1ps
`default_nettype none
module acm_adc_ctrl_tb;
	typedef struct {
		logic [7:0] thr;
		logic [9:0] lvl;
		logic       f;
	} acm_row_t;
	localparam logic [5:0] WR = 6'h20, ST = 6'h10, SK = 6'h08;
	localparam logic [5:0] LD = 6'h04, MV = 6'h02, AK = 6'h01;
	logic                mclk = 1'b0;
	logic                resetn = 1'b0;
	acm_pkg::acm_instr_t instr = '0;
	logic [3:0]          interrupt_select_reg = 4'h0;
	logic [9:0]          level = 10'h000;
	logic [1:0]          port_in_raw = 2'h0;
	logic                cmp_below, conv_done_flag, irq_request, skip_next, busy, sk;
	logic [3:0]          converter_control_reg, acc_a_low_result;
	logic [9:0]          dac_code, result_read;
	logic [7:0]          threshold_read;
	logic [1:0]          analog_sel, port_in_digital;
	int                  err_total = 0;
	int                  cmp_count = 0;
	int                  n;
	// Equal level and reference must not count as below
	acm_row_t rows [5] = '{'{8'h80, 10'h1ff, 1'b1}, '{8'h80, 10'h200, 1'b0},
		'{8'hff, 10'h3fb, 1'b1}, '{8'h00, 10'h000, 1'b0}, '{8'h01, 10'h003, 1'b1}};
	acm_adc_ctrl u_acm_adc_ctrl (.mclk(mclk), .resetn(resetn), .instr(instr),
		.interrupt_select_reg(interrupt_select_reg), .cmp_below(cmp_below),
		.port_in_raw(port_in_raw), .converter_control_reg(converter_control_reg),
		.conv_done_flag(conv_done_flag), .irq_request(irq_request), .skip_next(skip_next),
		.dac_code(dac_code), .analog_sel(analog_sel), .busy(busy),
		.threshold_read(threshold_read), .result_read(result_read),
		.acc_a_low_result(acc_a_low_result), .port_in_digital(port_in_digital));
	acm_analog_model u_acm_analog_model (.dac_code(dac_code), .analog_level(level),
		.cmp_below(cmp_below));
	// Free-running machine clock, 25 ns period
	initial begin
		forever #12.5 mclk = ~mclk;
	end
	task chk(input string nm, input logic [9:0] seen, input logic [9:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// One-cycle strobe; skip answer is sampled while the strobe stands
	task issue(input logic [5:0] s, input logic [3:0] d, a, b, output logic skv);
		@(posedge mclk);
		instr <= '{s[5], d, s[4], s[3], s[2], s[1], s[0], a, b};
		@(negedge mclk);
		skv = skip_next;
		@(posedge mclk);
		instr <= '0;
	endtask : issue
	// Bounded wait, counting busy cycles after the start is taken
	task wait_idle(output int cnt);
		cnt = 0;
		@(negedge mclk);
		while (busy === 1'b1 && cnt < 200) begin
			cnt++;
			@(negedge mclk);
		end
	endtask : wait_idle
	task complete_run;
		$display("Compares %0d errors %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : complete_run
	// Watchdog well beyond the few hundred cycles the sequence needs
	initial begin
		#(25 * 4000);
		err_total++;
		complete_run();
	end
	initial begin
		repeat (6) @(posedge mclk);
		resetn <= 1'b1;
		port_in_raw <= 2'h3;
		@(negedge mclk);
		chk("ctrl_rst", {6'h00, converter_control_reg}, 10'h000);
		chk("flag_rst", {9'h000, conv_done_flag}, 10'h000);
		chk("dac_rst", dac_code, 10'h200);
		issue(WR, 4'h8, 4'h0, 4'h0, sk);
		@(negedge mclk);
		chk("ctrl_cmp", {6'h00, converter_control_reg}, 10'h008);
		// Table of comparator cases in poll mode
		for (int i = 0; i < 5; i++) begin
			level <= rows[i].lvl;
			issue(LD, 4'h0, rows[i].thr[3:0], rows[i].thr[7:4], sk);
			@(negedge mclk);
			chk("threshold", {2'h0, threshold_read}, {2'h0, rows[i].thr});
			chk("dac_ref", dac_code, {rows[i].thr, 2'h0});
			issue(ST, 4'h0, 4'h0, 4'h0, sk);
			wait_idle(n);
			chk("cmp_len", n[9:0], 10'h008);
			chk("cmp_flag", {9'h000, conv_done_flag}, {9'h000, rows[i].f});
			issue(SK, 4'h0, 4'h0, 4'h0, sk);
			chk("skip", {9'h000, sk}, {9'h000, rows[i].f});
			@(negedge mclk);
			chk("flag_clr", {9'h000, conv_done_flag}, 10'h000);
		end
		// Back to conversion on input one, select bit already clear
		issue(WR, 4'h1, 4'h0, 4'h0, sk);
		issue(SK, 4'h0, 4'h0, 4'h0, sk);
		@(negedge mclk);
		chk("flag_mode", {9'h000, conv_done_flag}, 10'h000);
		issue(LD, 4'h0, 4'hf, 4'hf, sk);
		@(negedge mclk);
		chk("thr_hidden", {2'h0, threshold_read}, 10'h000);
		chk("sel_one", {8'h00, analog_sel}, 10'h001);
		chk("port_dig", {8'h00, port_in_digital}, 10'h001);
		level <= 10'h2a5;
		issue(ST, 4'h0, 4'h0, 4'h0, sk);
		wait_idle(n);
		chk("conv_len", n[9:0], 10'h03e);
		chk("conv_flag", {9'h000, conv_done_flag}, 10'h001);
		chk("result", result_read, 10'h2a5);
		// Acknowledge in poll mode must leave the flag alone
		issue(AK, 4'h0, 4'h0, 4'h0, sk);
		@(negedge mclk);
		chk("ack_poll", {9'h000, conv_done_flag}, 10'h001);
		// Interrupt mode: skip must not clear, acknowledge must
		@(posedge mclk);
		interrupt_select_reg <= 4'h4;
		@(negedge mclk);
		chk("irq", {9'h000, irq_request}, 10'h001);
		issue(SK, 4'h0, 4'h0, 4'h0, sk);
		chk("skip_irq", {9'h000, sk}, 10'h000);
		@(negedge mclk);
		chk("flag_kept", {9'h000, conv_done_flag}, 10'h001);
		issue(AK, 4'h0, 4'h0, 4'h0, sk);
		@(negedge mclk);
		chk("flag_ack", {9'h000, conv_done_flag}, 10'h000);
		@(posedge mclk);
		interrupt_select_reg <= 4'h0;
		issue(MV, 4'h0, 4'hf, 4'h0, sk);
		@(negedge mclk);
		chk("low_bits", {6'h00, acc_a_low_result}, 10'h004);
		issue(WR, 4'h8, 4'h0, 4'h0, sk);
		@(negedge mclk);
		chk("thr_kept", {2'h0, threshold_read}, 10'h001);
		issue(WR, 4'h2, 4'h0, 4'h0, sk);
		@(negedge mclk);
		chk("sel_bad", {8'h00, analog_sel}, 10'h000);
		complete_run();
	end
endmodule : acm_adc_ctrl_tb
`default_nettype wire

/* verif/acm_analog_model.sv */
// Analog front end model: input level compared against the DAC reference
`timescale 1ns/1ps
`default_nettype none
module acm_analog_model (
	input  wire logic [9:0] dac_code,
	input  wire logic [9:0] analog_level,
	output logic            cmp_below
);
	// Level on a 1024 scale, so a threshold code n at dac {n,00} sits at n/256
	assign cmp_below = (analog_level < dac_code);
endmodule : acm_analog_model
`default_nettype wire
